// ===== pkg/adct_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the converter timing block
// Assumes: Byte addresses on a 32-bit register bus
// Notes: Definitions only
`ifndef ADCT_CONSTS_SVH
`define ADCT_CONSTS_SVH

// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define ADCT_OFF_TIMING 8'h00
`define ADCT_OFF_TEST 8'h04
`define ADCT_OFF_CTRL 8'h08
`define ADCT_OFF_STATUS 8'h0c
`define ADCT_OFF_RESULT 8'h10

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define ADCT_CTRL_START_BIT 0
`define ADCT_CTRL_TENBIT_BIT 1
`define ADCT_STAT_BUSY_BIT 0
`define ADCT_STAT_DONE_BIT 1

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define ADCT_TIMING_RST 8'h00
`define ADCT_TEST_RST 6'h00

// ----------------------------------------------------------
// Timing counts in oscillator periods, bit counts, bit indices and the first trial code
// ----------------------------------------------------------
`define ADCT_SAMPLE_EXTRA 10'h002
`define ADCT_CONVERT_LENGTH_FIELD_EXTRA 10'h003
`define ADCT_TAIL_LOAD 10'h002
`define ADCT_BITS_8 10'h008
`define ADCT_BITS_10 10'h00a
`define ADCT_MSB_IDX 4'h9
`define ADCT_LSB_IDX_8 4'h2
`define ADCT_LSB_IDX_10 4'h0
`define ADCT_MSB_CODE 10'h200

// ----------------------------------------------------------
// Bus answers
// ----------------------------------------------------------
`define ADCT_RESP_OKAY 2'b00
`define ADCT_RESP_SLVERR 2'b10

`endif

// ===== pkg/adct_pkg.sv
// Purpose: Types shared by the converter timing block
// Assumes: Constants come from adct_consts.svh
// Notes: Types only
package adct_pkg;

   // Software-loaded timing byte
   typedef struct packed {
      logic [2:0] sample_length_field;
      logic [4:0] convert_length_field;
   } adct_timing_t;

   // Test register fields
   typedef struct packed {
      logic [3:0] zero_trim;
      logic [1:0] input_sel;
   } adct_test_t;

   // Converter input selection
   typedef enum logic [1:0] {
      ADCT_IN_CHANNEL = 2'h0,
      ADCT_IN_GROUND = 2'h1,
      ADCT_IN_REFERENCE = 2'h2
   } adct_insel_t;

   // Sequencer states
   typedef enum {ST_IDLE, ST_SAMPLE, ST_STEP, ST_TAIL} adct_state_t;

endpackage

// ===== verilog/adct_sar_core.sv
// Purpose: Sample and successive-approximation sequencer
// Assumes: Comparator input already synchronised to sys_clk
// Notes: Timing fields and resolution are caught at start
`timescale 1ns/1ps
`include "adct_consts.svh"

module adct_sar_core
   import adct_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Control
   input wire logic start,
   input wire logic ten_bit,
   input wire adct_timing_t timing,
   input wire logic cmp_high,
   // Status and analog side
   output logic busy,
   output logic done,
   output logic sample_en,
   output logic [9:0] dac_code,
   output logic [9:0] result
);

   // ----------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------
   adct_state_t state_reg;
   logic [9:0] cnt_reg;
   logic [3:0] bit_reg;
   logic [9:0] code_reg;
   logic [9:0] result_reg;
   logic done_reg;
   logic mode_reg;
   adct_timing_t lat_reg;
   logic [3:0] lsb_idx;

   assign lsb_idx = mode_reg ? `ADCT_LSB_IDX_10 : `ADCT_LSB_IDX_8;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 10'h000;
         bit_reg <= 4'h0;
         code_reg <= 10'h000;
         mode_reg <= 1'b0;
         lat_reg <= '0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (start)
               begin
                  // sample length 8 per unit plus 2
                  state_reg <= ST_SAMPLE;
                  cnt_reg <= {4'h0, timing.sample_length_field, 3'b000} + `ADCT_SAMPLE_EXTRA - 10'h001;
                  mode_reg <= ten_bit;
                  lat_reg <= timing;
               end
            end
            ST_SAMPLE:
            begin
               if (cnt_reg == 10'h000)
               begin
                  state_reg <= ST_STEP;
                  cnt_reg <= {4'h0, lat_reg.convert_length_field, 1'b1};
                  bit_reg <= `ADCT_MSB_IDX;
                  code_reg <= `ADCT_MSB_CODE;
               end
               else
                  cnt_reg <= cnt_reg - 10'h001;
            end
            ST_STEP:
            begin
               if (cnt_reg == 10'h000)
               begin
                  code_reg[bit_reg] <= cmp_high;
                  if (bit_reg == lsb_idx)
                  begin
                     state_reg <= ST_TAIL;
                     cnt_reg <= `ADCT_TAIL_LOAD;
                  end
                  else
                  begin
                     bit_reg <= bit_reg - 4'h1;
                     code_reg[bit_reg - 4'h1] <= 1'b1;
                     cnt_reg <= {4'h0, lat_reg.convert_length_field, 1'b1};
                  end
               end
               else
                  cnt_reg <= cnt_reg - 10'h001;
            end
            ST_TAIL:
            begin
               if (cnt_reg == 10'h000)
                  state_reg <= ST_IDLE;
               else
                  cnt_reg <= cnt_reg - 10'h001;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // Result capture and done pulse
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         result_reg <= 10'h000;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= (state_reg == ST_TAIL) && (cnt_reg == 10'h000);
         if ((state_reg == ST_TAIL) && (cnt_reg == 10'h000))
            result_reg <= code_reg;
      end
   end

   // Outputs
   assign busy = (state_reg != ST_IDLE);
   assign sample_en = (state_reg == ST_SAMPLE);
   assign dac_code = code_reg;
   assign result = result_reg;
   assign done = done_reg;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   logic [9:0] phase_cyc;
   logic [9:0] convert_length_field_cyc;
   logic [3:0] step_cnt;
   logic [9:0] exp_sample;
   logic [9:0] exp_convert_length_field;
   logic [9:0] bsel;

   assign bsel = mode_reg ? `ADCT_BITS_10 : `ADCT_BITS_8;
   assign exp_sample = {4'h0, lat_reg.sample_length_field, 3'b000} + 10'h002;
   assign exp_convert_length_field = 10'(bsel * ({5'h00, lat_reg.convert_length_field} + 10'h001) * 10'h002 + 10'h003);

   // Cycle counters for the checks
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_cyc <= 10'h000;
         convert_length_field_cyc <= 10'h000;
         step_cnt <= 4'h0;
      end
      else
      begin
         phase_cyc <= sample_en ? phase_cyc + 10'h001 : 10'h000;
         convert_length_field_cyc <= (state_reg == ST_STEP || state_reg == ST_TAIL) ? convert_length_field_cyc + 10'h001 : 10'h000;
         if (state_reg == ST_SAMPLE)
            step_cnt <= 4'h0;
         else if (state_reg == ST_STEP && cnt_reg == 10'h000)
            step_cnt <= step_cnt + 4'h1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sample_len_a: assert property ($fell(sample_en) |-> $past(phase_cyc) + 10'h001 == exp_sample)
      else $error("sample phase length wrong");
   convert_length_field_len_a: assert property (done |-> convert_length_field_cyc == exp_convert_length_field)
      else $error("conversion phase length wrong");
   step_count_a: assert property (done |-> step_cnt == bsel[3:0])
      else $error("bit step count wrong");
   start_busy_a: assert property (start && !busy |=> sample_en ##0 busy)
      else $error("start not taken");
   any_field_a: assert property ($rose(busy) |-> ##[1:701] done)
      else $error("conversion did not finish");
   done_pulse_a: assert property (done && !start |=> !done ##0 !busy)
      else $error("done not a single pulse");
   dac_hold_a: assert property (state_reg == ST_STEP && cnt_reg != 10'h000 |=> $stable(dac_code))
      else $error("trial code moved mid step");
   result_match_a: assert property (done |-> result == dac_code)
      else $error("result not the final code");

endmodule // adct_sar_core

// ===== verilog/adct_top.sv
// Purpose: Converter timing control with AXI4-Lite registers
// Assumes: sys_clk is the oscillator clock; comparator arrives from the analog side
// Notes: One write and one read in flight at a time
`timescale 1ns/1ps
`include "adct_consts.svh"

module adct_top
   import adct_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog side
   input wire logic cmp_in,
   output logic sample_en,
   output logic [9:0] dac_code,
   output logic [1:0] input_sel,
   output logic [3:0] zero_trim
);

   // ----------------------------------------------------------
   // Registers
   // ----------------------------------------------------------
   adct_timing_t timing_reg;
   adct_test_t test_reg;
   logic ten_bit_reg;
   logic start_reg;
   logic done_flag_reg;
   logic busy;
   logic done;
   logic [9:0] result;

   // Comparator synchroniser
   logic cmp_meta_reg;
   logic cmp_sync_reg;

   // Two flops before any use
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
      end
      else
      begin
         cmp_meta_reg <= cmp_in;
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   // ----------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------
   logic aw_got_reg;
   logic w_got_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic wr_fire;
   logic wr_hit;

   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready = !w_got_reg && !bvalid_reg;
   assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   assign wr_hit = ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_TIMING) || ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_TEST)
      || ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_CTRL) || ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_STATUS);
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Address and data taken in either order, answer after both
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `ADCT_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `ADCT_RESP_OKAY : `ADCT_RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // software timing byte, test and control
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timing_reg <= `ADCT_TIMING_RST;
         test_reg <= `ADCT_TEST_RST;
         ten_bit_reg <= 1'b0;
         start_reg <= 1'b0;
      end
      else
      begin
         start_reg <= 1'b0;
         if (wr_fire && wstrb_reg[0])
         begin
            if ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_TIMING)
               timing_reg <= wdata_reg[7:0];
            else if ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_TEST)
               test_reg <= wdata_reg[5:0];
            else if ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_CTRL)
            begin
               ten_bit_reg <= wdata_reg[`ADCT_CTRL_TENBIT_BIT];
               start_reg <= wdata_reg[`ADCT_CTRL_START_BIT];
            end
         end
      end
   end

   // Sticky done, a new completion wins over the clear
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         done_flag_reg <= 1'b0;
      else if (done)
         done_flag_reg <= 1'b1;
      else if (wr_fire && wstrb_reg[0] && ({waddr_reg[7:2], 2'b00} == `ADCT_OFF_STATUS)
         && wdata_reg[`ADCT_STAT_DONE_BIT])
         done_flag_reg <= 1'b0;
   end

   // ----------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Read decode, unmapped reads zero with an error
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `ADCT_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `ADCT_RESP_OKAY;
         if ({s_axi_araddr[7:2], 2'b00} == `ADCT_OFF_TIMING)
            rdata_reg <= {24'h00_0000, timing_reg};
         else if ({s_axi_araddr[7:2], 2'b00} == `ADCT_OFF_TEST)
            rdata_reg <= {26'h0, test_reg};
         else if ({s_axi_araddr[7:2], 2'b00} == `ADCT_OFF_CTRL)
            rdata_reg <= {30'h0, ten_bit_reg, 1'b0};
         else if ({s_axi_araddr[7:2], 2'b00} == `ADCT_OFF_STATUS)
            rdata_reg <= {30'h0, done_flag_reg, busy};
         else if ({s_axi_araddr[7:2], 2'b00} == `ADCT_OFF_RESULT)
            rdata_reg <= {22'h0, result};
         else
         begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `ADCT_RESP_SLVERR;
         end
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // ----------------------------------------------------------
   // Sequencer and analog controls
   // ----------------------------------------------------------
   adct_sar_core u_core (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .start(start_reg),
      .ten_bit(ten_bit_reg),
      .timing(timing_reg),
      .cmp_high(cmp_sync_reg),
      .busy(busy),
      .done(done),
      .sample_en(sample_en),
      .dac_code(dac_code),
      .result(result)
   );

   // test input select and zero trim
   assign input_sel = test_reg.input_sel;
   assign zero_trim = test_reg.zero_trim;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   bresp_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   timing_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_fire && wstrb_reg[0] && {waddr_reg[7:2], 2'b00} == `ADCT_OFF_TIMING |=> timing_reg == $past(wdata_reg[7:0]))
      else $error("timing byte not loaded");
   test_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_fire && wstrb_reg[0] && {waddr_reg[7:2], 2'b00} == `ADCT_OFF_TEST |=> input_sel == $past(wdata_reg[1:0]))
      else $error("test select not applied");
   done_sticky_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      done |=> done_flag_reg)
      else $error("done flag lost");

endmodule // adct_top

// ===== verif/adct_testbench.sv
// Purpose: Self-checking bench for the converter timing block
// Assumes: Response latencies and register map as the designer states them
// Notes: Bench drives the AXI4-Lite bus and comparator input directly
`timescale 1ns/1ps
`include "adct_consts.svh"

module testbench
   import adct_pkg::*;
;
   logic sys_clk, arst_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, zero_trim;
   logic [1:0] s_axi_bresp, s_axi_rresp, input_sel;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmp_in, sample_en;
   logic [9:0] dac_code;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int samp_cnt = 0;
   int t_rise = 0;
   logic samp_prev = 1'b0;

   adct_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmp_in(cmp_in),
      .sample_en(sample_en), .dac_code(dac_code), .input_sel(input_sel), .zero_trim(zero_trim));

   // ----------------------------------------------------------
   // Clock, cycle count, timeout and sample monitor
   // ----------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Counts sample phase length and notes its first cycle
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      samp_prev <= sample_en;
      if (sample_en === 1'b1 && samp_prev !== 1'b1)
      begin
         samp_cnt <= 1;
         t_rise <= cyc;
      end
      else if (sample_en === 1'b1)
         samp_cnt <= samp_cnt + 1;
      if (cyc == 20000)
      begin
         failures = failures + 1;
         results();
      end
   end

   // ----------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checked = checked + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic results();
      $display("mismatches %0d, comparisons %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge sys_clk);
         if (!aw_done && s_axi_awready === 1'b1)
         begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1)
         begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   // Reset values, unmapped place refused
   task automatic reset_and_map();
      logic [31:0] d;
      logic [1:0] r;
      check(sample_en, 0, "idle sample enable");
      check({input_sel, zero_trim}, 0, "test outputs at reset");
      axi_read(`ADCT_OFF_TIMING, d, r);
      check(d, 32'h0000_0000, "timing reset");
      axi_read(8'h14, d, r);
      check(r, `ADCT_RESP_SLVERR, "unmapped read answer");
      check(d, 32'h0, "unmapped read data");
      axi_write(8'h14, 32'h0000_00ff, r);
      check(r, `ADCT_RESP_SLVERR, "unmapped write");
   endtask

   // Both fields share one byte, upper bits dropped
   task automatic timing_byte();
      logic [31:0] d;
      logic [1:0] r;
      axi_write(`ADCT_OFF_TIMING, 32'hffff_ff5a, r);
      axi_read(`ADCT_OFF_TIMING, d, r);
      check(d, 32'h0000_005a, "timing byte readback");
      axi_write(`ADCT_OFF_TIMING, 32'h0000_00a5, r);
      axi_read(`ADCT_OFF_TIMING, d, r);
      check(r, `ADCT_RESP_OKAY, "timing read answer");
      check(d, 32'h0000_00a5, "timing byte readback");
      // Lane 0 strobe off leaves the byte alone
      s_axi_wstrb <= 4'he;
      axi_write(`ADCT_OFF_TIMING, 32'h0000_0033, r);
      s_axi_wstrb <= 4'hf;
      check(r, `ADCT_RESP_OKAY, "lane 0 off answer");
      axi_read(`ADCT_OFF_TIMING, d, r);
      check(d, 32'h0000_00a5, "lane 0 off kept");
   endtask

   // Ground and reference selection with offset trim
   task automatic test_register();
      logic [31:0] d;
      logic [1:0] r;
      adct_insel_t sel [2] = '{ADCT_IN_GROUND, ADCT_IN_REFERENCE};
      foreach (sel[i])
      begin
         axi_write(`ADCT_OFF_TEST, {26'h0, 4'hc - 4'(i), 2'(sel[i])}, r);
         axi_read(`ADCT_OFF_TEST, d, r);
         check(d, {26'h0, 4'hc - 4'(i), 2'(sel[i])}, "test readback");
         check({input_sel, zero_trim}, {2'(sel[i]), 4'hc - 4'(i)}, "test outputs");
      end
   endtask

   // One conversion, timing byte rewritten while busy
   task automatic run_convert_length_field(input logic [2:0] s, input logic [4:0] c, input logic ten, input logic cmp);
      logic [31:0] d;
      logic [1:0] r;
      int exp_total, t_done;
      logic [31:0] exp_res;
      cmp_in <= cmp;
      exp_total = 8 * s + 2 + 2 * (ten ? 10 : 8) * (c + 1) + 3;
      exp_res = cmp ? (ten ? 32'h3ff : 32'h3fc) : 32'h0;
      axi_write(`ADCT_OFF_TIMING, {24'h0, s, c}, r);
      axi_write(`ADCT_OFF_CTRL, {30'h0, ten, 1'b1}, r);
      axi_write(`ADCT_OFF_TIMING, 32'h0000_00ff, r);
      repeat (exp_total - 5) @(posedge sys_clk);
      do axi_read(`ADCT_OFF_STATUS, d, r); while (d[1] !== 1'b1);
      t_done = cyc;
      check(samp_cnt, 8 * s + 2, "sample length");
      check(32'(t_done - t_rise >= exp_total && t_done - t_rise <= exp_total + 8), 1, "busy length");
      check(d[0], 0, "busy after done");
      check(dac_code, exp_res, "final trial code");
      axi_read(`ADCT_OFF_RESULT, d, r);
      check(d, exp_res, "result code");
      axi_write(`ADCT_OFF_STATUS, 32'h0000_0002, r);
      axi_read(`ADCT_OFF_STATUS, d, r);
      check(d[1:0], 2'b00, "done cleared");
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial
   begin
      arst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmp_in} = '0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      reset_and_map();
      timing_byte();
      test_register();
      // Lowest legal fields in 8-bit mode
      run_convert_length_field(3'h1, 5'h02, 1'b0, 1'b1);
      // Highest legal fields in 10-bit mode
      run_convert_length_field(3'h7, 5'h1f, 1'b1, 1'b0);
      // Times inside the accurate window at 20 MHz
      run_convert_length_field(3'h3, 5'h09, 1'b1, 1'b0);
      // Fields outside the accurate window still sequence
      run_convert_length_field(3'h0, 5'h00, 1'b1, 1'b1);
      results();
   end
endmodule // testbench
